// *** core/pulse_width_timer.sv ***
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module pulse_width_timer (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic [1:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output var  logic [7:0] regRdata,
   input  wire logic       timerInput,
   input  wire logic       standby,
   output var  logic       irqOut,
   output var  logic       wakeOut
);
   import pwt_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pwt_ctrl_s    ctrl_ff;
   pwt_state_e   state_ff;
   pwt_state_e   nxt_state;
   logic [15:0]  count_ff;
   logic [15:0]  preload_ff;
   logic [7:0]   lowBuf_ff;
   logic [7:0]   readLatch_ff;
   logic [PSC_W-1:0] psc_ff;
   logic         pinSync1_ff;
   logic         pinSync2_ff;
   logic         pinPrev_ff;
   logic         irqFlag_ff;
   logic         irqEn_ff;
   logic         flagAtEntry_ff;
   logic         standbyPrev_ff;
   logic         pendStart_ff;
   logic         pendStop_ff;
   logic         tick;
   logic         inhibit;
   logic         startEdge;
   logic         stopEdge;
   logic         counting;
   logic         overflow;
   logic         autoClear;
   logic         wrCtrl;
   logic         wrHigh;
   logic         wrLow;
   logic         wrIrq;
   logic         rdHigh;
   logic         rdCnt;

   // Selected prescaler tap: bit n toggles at clock / 2^(n+1)
   function automatic logic tapFall(input logic [PSC_W-1:0] cur, input logic [2:0] sel);
      logic [PSC_W:0] nxtVal;
      nxtVal = {1'b0, cur} + {{PSC_W{1'b0}}, 1'b1};
      if (sel == 3'h0) begin
         tapFall = 1'b1;
      end else begin
         tapFall = cur[sel - 3'h1] & ~nxtVal[sel - 3'h1];
      end
   endfunction

   function automatic logic isAddr(input logic [1:0] a, input logic [1:0] off);
      isAddr = (a == off);
   endfunction

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   assign wrCtrl = regWrite & isAddr(regAddr, OFF_CTRL);
   assign wrLow  = regWrite & isAddr(regAddr, OFF_CNT_L);
   assign wrHigh = regWrite & isAddr(regAddr, OFF_CNT_H);
   assign wrIrq  = regWrite & isAddr(regAddr, OFF_IRQ);
   assign rdHigh = regRead & isAddr(regAddr, OFF_CNT_H);
   assign rdCnt  = regRead & (isAddr(regAddr, OFF_CNT_H) | isAddr(regAddr, OFF_CNT_L));

   // Tick blanked during counter reads and preload writes
   assign inhibit = rdCnt | wrHigh | wrLow;
   assign tick    = tapFall(psc_ff, ctrl_ff.psc) & ~inhibit;

   // ----------------------------------------------------------------
   // Input pin synchroniser and edge detect
   // ----------------------------------------------------------------
   // Two flops against metastability; edges from a third registered copy
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pinSync1_ff <= 1'b0;
         pinSync2_ff <= 1'b0;
         pinPrev_ff  <= 1'b0;
      end else begin
         pinSync1_ff <= timerInput;
         pinSync2_ff <= pinSync1_ff;
         pinPrev_ff  <= pinSync2_ff;
      end
   end

   // Edge polarity follows the edge select bit
   assign startEdge = ctrl_ff.edgeRise ? (pinSync2_ff & ~pinPrev_ff)
                                       : (~pinSync2_ff & pinPrev_ff);
   assign stopEdge  = ctrl_ff.edgeRise ? (~pinSync2_ff & pinPrev_ff)
                                       : (pinSync2_ff & ~pinPrev_ff);

   // Edges are held until the next tick so start and stop edges move the FSM on ticks only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pendStart_ff <= 1'b0;
         pendStop_ff  <= 1'b0;
      end else begin
         pendStart_ff <= (state_ff == ST_ARMED) & ~tick & (pendStart_ff | startEdge);
         pendStop_ff  <= (state_ff == ST_COUNT) & ~tick & (pendStop_ff | stopEdge);
      end
   end

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Free running, so the tick phase is not tied to the pin edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         psc_ff <= '0;
      end else begin
         psc_ff <= psc_ff + {{(PSC_W-1){1'b0}}, 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // Measurement state machine
   // ----------------------------------------------------------------
   // Only pulse mode walks the machine; other modes sit in idle
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (ctrl_ff.enable && ctrl_ff.mode == MODE_PULSE) begin
               nxt_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!ctrl_ff.enable || ctrl_ff.mode != MODE_PULSE) begin
               nxt_state = ST_IDLE;
            end else if (tick && (pendStart_ff || startEdge)) begin
               nxt_state = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (!ctrl_ff.enable || ctrl_ff.mode != MODE_PULSE) begin
               nxt_state = ST_IDLE;
            end else if (tick && (pendStop_ff || stopEdge)) begin
               nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Self-clear only ever fires from pulse mode
   assign autoClear = (state_ff == ST_COUNT) & (nxt_state == ST_IDLE) & ctrl_ff.enable
                      & (ctrl_ff.mode == MODE_PULSE);
   assign counting  = (state_ff == ST_COUNT) & tick & ~autoClear;
   assign overflow  = counting & (count_ff == CNT_FULL);

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // Software write wins; hardware clears enable at end of pulse
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= {CTRL_RESET[CTRL_MODE_HI:CTRL_MODE_LO], CTRL_RESET[CTRL_EN_BIT],
                     CTRL_RESET[CTRL_EDGE_BIT], CTRL_RESET[CTRL_PSC_HI:CTRL_PSC_LO]};
      end else if (wrCtrl) begin
         ctrl_ff.mode     <= regWdata[CTRL_MODE_HI:CTRL_MODE_LO];
         ctrl_ff.enable   <= regWdata[CTRL_EN_BIT];
         ctrl_ff.edgeRise <= regWdata[CTRL_EDGE_BIT];
         ctrl_ff.psc      <= regWdata[CTRL_PSC_HI:CTRL_PSC_LO];
      end else if (autoClear) begin
         ctrl_ff.enable <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Preload and counter
   // ----------------------------------------------------------------
   // High-byte write commits buffered low byte with it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         lowBuf_ff  <= CNT_RESET[7:0];
         preload_ff <= CNT_RESET;
      end else begin
         if (wrLow) begin
            lowBuf_ff <= regWdata;
         end
         if (wrHigh) begin
            preload_ff <= {regWdata, lowBuf_ff};
         end
      end
   end

   // Disabled: preload lands at once; running: waits for overflow
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_ff <= CNT_RESET;
      end else if (wrHigh && !ctrl_ff.enable) begin
         count_ff <= {regWdata, lowBuf_ff};
      end else if (overflow) begin
         count_ff <= preload_ff;
      end else if (counting) begin
         count_ff <= count_ff + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt flag, enable and wake
   // ----------------------------------------------------------------
   // Overflow beats a same-cycle software clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irqFlag_ff <= 1'b0;
         irqEn_ff   <= 1'b0;
      end else begin
         if (overflow) begin
            irqFlag_ff <= 1'b1;
         end else if (wrIrq) begin
            irqFlag_ff <= regWdata[IRQ_FLAG_BIT];
         end
         if (wrIrq) begin
            irqEn_ff <= regWdata[IRQ_EN_BIT];
         end
      end
   end

   // Flag sampled on standby entry decides whether wake is allowed
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         standbyPrev_ff <= 1'b0;
         flagAtEntry_ff <= 1'b0;
      end else begin
         standbyPrev_ff <= standby;
         if (standby && !standbyPrev_ff) begin
            flagAtEntry_ff <= irqFlag_ff;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irqOut  <= 1'b0;
         wakeOut <= 1'b0;
      end else begin
         irqOut <= irqFlag_ff & irqEn_ff;
         // Wake ignores interrupt enable
         wakeOut <= standby & standbyPrev_ff & overflow & ~flagAtEntry_ff;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // High-byte read snapshots low byte so the pair stays coherent
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         readLatch_ff <= 8'h00;
         regRdata     <= 8'h00;
      end else begin
         if (rdHigh) begin
            readLatch_ff <= count_ff[7:0];
         end
         regRdata <= 8'h00;
         if (regRead) begin
            unique case (regAddr)
               OFF_CTRL:  regRdata <= {ctrl_ff.mode, 1'b0, ctrl_ff.enable,
                                       ctrl_ff.edgeRise, ctrl_ff.psc};
               OFF_CNT_L: regRdata <= readLatch_ff;
               OFF_CNT_H: regRdata <= count_ff[15:8];
               OFF_IRQ:   regRdata <= {6'h00, irqEn_ff, irqFlag_ff};
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_countPhase;
      state_ff == ST_COUNT;
   endsequence

   sequence s_stopTick;
      tick && (pendStop_ff || stopEdge);
   endsequence

   a_auto_clear_en: assert property (@(posedge mclk) disable iff (!resetn)
      (s_countPhase ##0 s_stopTick ##0 (ctrl_ff.enable && !wrCtrl &&
       ctrl_ff.mode == MODE_PULSE)) |=> !ctrl_ff.enable)
      else $error("enable not cleared at pulse end");

   a_no_hw_clear: assert property (@(posedge mclk) disable iff (!resetn)
      (ctrl_ff.enable && ctrl_ff.mode != MODE_PULSE && !wrCtrl) |=> ctrl_ff.enable)
      else $error("enable cleared outside pulse mode");

   a_armed_hold: assert property (@(posedge mclk) disable iff (!resetn)
      (state_ff == ST_ARMED && !tick && !wrHigh) |=> $stable(count_ff))
      else $error("counter moved while only armed");

   a_ignore_after: assert property (@(posedge mclk) disable iff (!resetn)
      (!ctrl_ff.enable && !wrCtrl) |=> state_ff == ST_IDLE)
      else $error("measurement restarted without enable");

   a_overflow_reload: assert property (@(posedge mclk) disable iff (!resetn)
      overflow |=> (count_ff == $past(preload_ff)) && irqFlag_ff)
      else $error("overflow did not reload and flag");

   a_count_step: assert property (@(posedge mclk) disable iff (!resetn)
      (counting && !overflow && !wrHigh) |=> count_ff == $past(count_ff) + 16'h0001)
      else $error("counter step wrong");

   a_inhibit_tick: assert property (@(posedge mclk) disable iff (!resetn)
      (rdCnt && state_ff == ST_COUNT && !wrHigh) |=> $stable(count_ff))
      else $error("counter moved during read");

   a_preload_direct: assert property (@(posedge mclk) disable iff (!resetn)
      (wrHigh && !ctrl_ff.enable) |=> count_ff == {$past(regWdata), $past(lowBuf_ff)})
      else $error("disabled preload not loaded");

   a_irq_gate: assert property (@(posedge mclk) disable iff (!resetn)
      (irqFlag_ff && !irqEn_ff) |=> !irqOut)
      else $error("interrupt without enable");

   a_wake_out: assert property (@(posedge mclk) disable iff (!resetn)
      (overflow && standby && standbyPrev_ff && !flagAtEntry_ff) |=> wakeOut)
      else $error("no wake on standby overflow");

   a_wake_block: assert property (@(posedge mclk) disable iff (!resetn)
      (flagAtEntry_ff && standbyPrev_ff) |=> !wakeOut)
      else $error("wake despite preset flag");

endmodule // pulse_width_timer

`default_nettype wire

// *** core/pwt_pkg.sv ***
package pwt_pkg;
   // Register offsets on the plain register port
   localparam logic [1:0] OFF_CTRL  = 2'h0;
   localparam logic [1:0] OFF_CNT_L = 2'h1;
   localparam logic [1:0] OFF_CNT_H = 2'h2;
   localparam logic [1:0] OFF_IRQ   = 2'h3;

   // Control register field positions
   localparam int CTRL_MODE_HI = 7;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_EN_BIT  = 4;
   localparam int CTRL_EDGE_BIT = 3;
   localparam int CTRL_PSC_HI  = 2;
   localparam int CTRL_PSC_LO  = 0;

   // Interrupt register field positions
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT   = 1;

   // Reset values and the counter full value
   localparam logic [7:0]  CTRL_RESET = 8'h08;
   localparam logic [15:0] CNT_RESET  = 16'h0000;
   localparam logic [15:0] CNT_FULL   = 16'hffff;

   // Operating modes
   localparam logic [1:0] MODE_EVENT = 2'h1;
   localparam logic [1:0] MODE_TIMER = 2'h2;
   localparam logic [1:0] MODE_PULSE = 2'h3;

   // Prescaler width: ratios 2^0 .. 2^7
   localparam int PSC_W = 7;

   typedef struct packed {
      logic [1:0] mode;
      logic       enable;
      logic       edgeRise;
      logic [2:0] psc;
   } pwt_ctrl_s;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_COUNT = 3'b100
   } pwt_state_e;
endpackage

// *** verif/pulse_width_timer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module pulse_width_timer_tb;
   import pwt_pkg::*;

   logic        mclk;
   logic        resetn;
   logic [1:0]  regAddr;
   logic [7:0]  regWdata;
   logic        regWrite;
   logic        regRead;
   logic [7:0]  regRdata;
   logic        timerInput;
   logic        standby;
   logic        irqOut;
   logic        wakeOut;
   int          errors = 0;
   int          compares = 0;
   int          wakeCnt = 0;
   logic [15:0] cnt;
   logic [15:0] held;
   logic [7:0]  rd;

   // ---------------------------------------------
   // Clock, design and pulse source
   // ---------------------------------------------
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   pulse_width_timer i_pulse_width_timer (
      .mclk       (mclk),
      .resetn     (resetn),
      .regAddr    (regAddr),
      .regWdata   (regWdata),
      .regWrite   (regWrite),
      .regRead    (regRead),
      .regRdata   (regRdata),
      .timerInput (timerInput),
      .standby    (standby),
      .irqOut     (irqOut),
      .wakeOut    (wakeOut)
   );

   pwt_pulse_src i_pwt_pulse_src (
      .mclk       (mclk),
      .timerInput (timerInput)
   );

   // Wake is a one-cycle pulse, so count every sighting
   always @(posedge mclk) begin
      if (wakeOut === 1'b1) wakeCnt++;
   end

   // ---------------------------------------------
   // Compare, bus and closing tasks
   // ---------------------------------------------
   task automatic checkEq(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Pin edges land on the next tick, so one tick of slack either way
   task automatic checkNear(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if ($isunknown(got) || (got > exp + 16'h1) || (got + 16'h1 < exp)) begin
         errors++;
         $display("Error at %0t: %s got %h near %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rdReg(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask

   // High byte first: it latches the low byte for the second read
   task automatic readCount;
      logic [7:0] hi;
      logic [7:0] lo;
      rdReg(OFF_CNT_H, hi);
      rdReg(OFF_CNT_L, lo);
      cnt = {hi, lo};
   endtask

   task automatic preload(input logic [15:0] v);
      wr(OFF_CNT_L, v[7:0]);
      wr(OFF_CNT_H, v[15:8]);
   endtask

   function automatic logic [7:0] ctl(logic [1:0] m, logic en, logic e, logic [2:0] p);
      return {m, 1'b0, en, e, p};
   endfunction

   task automatic summarize;
      $display("Comparisons %0d, errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset_preload;
      rdReg(OFF_CTRL, rd);
      checkEq({8'h00, rd}, {8'h00, CTRL_RESET}, "ctrl reset");
      readCount;
      checkEq(cnt, CNT_RESET, "count reset");
      preload(16'h1234);
      readCount;
      checkEq(cnt, 16'h1234, "preload while off");
      wr(OFF_CNT_L, 8'h56);
      readCount;
      checkEq(cnt, 16'h1234, "low byte alone");
      wr(OFF_CNT_H, 8'hab);
      readCount;
      checkEq(cnt, 16'hab56, "high byte commits both");
   endtask

   // Falling start, single shot, later edges ignored
   task automatic t_falling;
      preload(16'h0000);
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b1, 1'b0, 3'h0));
      repeat (20) @(posedge mclk);
      readCount;
      checkEq(cnt, 16'h0000, "armed but idle");
      i_pwt_pulse_src.pulse(20);
      repeat (8) @(posedge mclk);
      readCount;
      checkNear(cnt, 16'd20, "low pulse width");
      held = cnt;
      rdReg(OFF_CTRL, rd);
      checkEq({8'h00, rd}, {8'h00, ctl(MODE_PULSE, 1'b0, 1'b0, 3'h0)}, "self clear");
      i_pwt_pulse_src.pulse(20);
      repeat (8) @(posedge mclk);
      readCount;
      checkEq(cnt, held, "pulse after self clear");
   endtask

   // A static low level or a rising edge must not start a falling-edge run
   task automatic t_level;
      preload(16'h0000);
      i_pwt_pulse_src.rest(1'b0);
      // Let the falling edge clear the synchroniser before arming
      repeat (4) @(posedge mclk);
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b1, 1'b0, 3'h0));
      repeat (20) @(posedge mclk);
      readCount;
      checkEq(cnt, 16'h0000, "static low level");
      i_pwt_pulse_src.rest(1'b1);
      repeat (10) @(posedge mclk);
      readCount;
      checkEq(cnt, 16'h0000, "wrong edge");
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b0, 1'b0, 3'h0));
   endtask

   // Rising start with a divide-by-four tick
   task automatic t_rising;
      i_pwt_pulse_src.rest(1'b0);
      preload(16'h0000);
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b1, 1'b1, 3'h2));
      i_pwt_pulse_src.pulse(40);
      repeat (16) @(posedge mclk);
      readCount;
      checkNear(cnt, 16'd10, "prescaled width");
      rdReg(OFF_CTRL, rd);
      checkEq({8'h00, rd}, {8'h00, ctl(MODE_PULSE, 1'b0, 1'b1, 3'h2)}, "rise clear");
   endtask

   // Fixed-timing low pulse with two reads inside it; only the address differs
   task automatic measureRead(input logic [1:0] a, output logic [15:0] v);
      preload(16'h0000);
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b1, 1'b0, 3'h0));
      i_pwt_pulse_src.rest(1'b0);
      repeat (4) @(posedge mclk);
      rdReg(a, rd);
      rdReg(a, rd);
      i_pwt_pulse_src.rest(1'b1);
      repeat (8) @(posedge mclk);
      readCount;
      v = cnt;
   endtask

   // Counter reads mid-pulse each swallow one tick; control reads do not
   task automatic t_inhibit;
      logic [15:0] base;
      measureRead(OFF_CTRL, base);
      checkNear(base, 16'd9, "nine cycle pulse");
      measureRead(OFF_CNT_H, held);
      checkEq(held, base - 16'd2, "reads stall count");
   endtask

   // Other modes keep the enable bit across pin activity
   task automatic t_modes;
      logic [1:0] m;
      for (int i = 0; i < 2; i++) begin
         m = (i == 0) ? MODE_EVENT : MODE_TIMER;
         wr(OFF_CTRL, ctl(m, 1'b1, 1'b1, 3'h0));
         i_pwt_pulse_src.pulse(8);
         repeat (8) @(posedge mclk);
         rdReg(OFF_CTRL, rd);
         checkEq({8'h00, rd}, {8'h00, ctl(m, 1'b1, 1'b1, 3'h0)}, "enable kept");
         wr(OFF_CTRL, ctl(m, 1'b0, 1'b1, 3'h0));
      end
   endtask

   // Overflow reloads and keeps going; request gated by its enable
   task automatic t_overflow;
      i_pwt_pulse_src.rest(1'b1);
      preload(16'hfff0);
      wr(OFF_IRQ, 8'h00);
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b1, 1'b0, 3'h0));
      i_pwt_pulse_src.pulse(24);
      repeat (8) @(posedge mclk);
      readCount;
      checkNear(cnt, 16'hfff8, "reload after overflow");
      rdReg(OFF_IRQ, rd);
      checkEq({8'h00, rd}, 16'h0001, "request flag");
      checkEq({15'h0, irqOut}, 16'h0000, "masked request");
      wr(OFF_IRQ, 8'h03);
      repeat (2) @(posedge mclk);
      checkEq({15'h0, irqOut}, 16'h0001, "enabled request");
      wr(OFF_IRQ, 8'h02);
      repeat (2) @(posedge mclk);
      checkEq({15'h0, irqOut}, 16'h0000, "cleared request");
   endtask

   // Standby overflow wakes once; a flag set beforehand suppresses it
   task automatic t_wake;
      wr(OFF_IRQ, 8'h00);
      preload(16'hfff0);
      wakeCnt = 0;
      standby <= 1'b1;
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b1, 1'b0, 3'h0));
      i_pwt_pulse_src.pulse(24);
      repeat (8) @(posedge mclk);
      checkEq(16'(wakeCnt), 16'h0001, "standby wake");
      readCount;
      checkNear(cnt, 16'hfff8, "standby measure");
      standby <= 1'b0;
      wr(OFF_IRQ, 8'h01);
      preload(16'hfff0);
      standby <= 1'b1;
      wr(OFF_CTRL, ctl(MODE_PULSE, 1'b1, 1'b0, 3'h0));
      i_pwt_pulse_src.pulse(24);
      repeat (8) @(posedge mclk);
      checkEq(16'(wakeCnt), 16'h0001, "wake suppressed");
      standby <= 1'b0;
   endtask

   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      resetn   = 1'b0;
      regAddr  = 2'h0;
      regWdata = 8'h00;
      regWrite = 1'b0;
      regRead  = 1'b0;
      standby  = 1'b0;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      t_reset_preload();
      t_falling();
      t_level();
      t_rising();
      t_modes();
      t_overflow();
      t_wake();
      t_inhibit();
      summarize();
   end

   // Whole run is about five hundred cycles; forty times that means a hang
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      summarize();
   end
endmodule // pulse_width_timer_tb

`default_nettype wire

// *** verif/pwt_pulse_src.sv ***
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------
// External pulse source on the timer input pin
// ---------------------------------------------
module pwt_pulse_src (
   input  wire logic mclk,
   output var  logic timerInput
);
   // Pin rests high until told otherwise
   initial timerInput = 1'b1;

   // Move the pin to a new resting level
   task automatic rest(input logic lvl);
      @(posedge mclk);
      timerInput <= lvl;
   endtask

   // One pulse away from the resting level, width in mclk cycles
   task automatic pulse(input int width);
      logic idle;
      idle = timerInput;
      @(posedge mclk);
      timerInput <= ~idle;
      repeat (width) @(posedge mclk);
      timerInput <= idle;
   endtask
endmodule // pwt_pulse_src

`default_nettype wire
